// ---- design/speech_pkg.sv ----
// Function
// - busy goes low when start accepted
// - busy stays low until message finished
// - start ignored while busy is low
// - strobe low with select low starts
// - code captured on strobe rise; host holds
// - standby after over 3 s idle
// - start during standby wakes and plays
// - busy floats in standby
// - reset reinitializes, aborts, releases standby
// - standby stops oscillator, parks pins
// - all timing from 640 kHz clock
// - unsigned 9-bit samples to converter
// - sample rate 5, 6 or 8 kHz
// - voice output sinks nothing in standby
`default_nettype none

package speech_pkg;

    // ------------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------------
    localparam int SYS_HZ      = 20_000_000;
    localparam int OSC_HZ      = 640_000;
    localparam int OSC_DIV     = SYS_HZ / OSC_HZ;
    localparam int OSC_CNT_W   = 5;
    localparam int IDLE_S      = 3;
    localparam int IDLE_TICKS  = IDLE_S * OSC_HZ;
    localparam int IDLE_W      = 21;

    // ------------------------------------------------------------------
    // sample rates and message layout
    // ------------------------------------------------------------------
    localparam int RATE_5K_HZ  = 5_000;
    localparam int RATE_6K_HZ  = 6_000;
    localparam int RATE_8K_HZ  = 8_000;
    localparam int RATE_W      = 8;
    localparam logic [RATE_W-1:0] DIV_5K = RATE_W'(OSC_HZ / RATE_5K_HZ);
    localparam logic [RATE_W-1:0] DIV_6K = RATE_W'(OSC_HZ / RATE_6K_HZ);
    localparam logic [RATE_W-1:0] DIV_8K = RATE_W'(OSC_HZ / RATE_8K_HZ);
    localparam int CODE_W      = 8;
    localparam int SAMPLE_W    = 9;
    localparam int LEN_W       = 11;
    localparam int LEN_SHIFT   = 4;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MID  = 9'h100;
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 9'h000;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARM     = 2'b01,
        ST_PLAY    = 2'b10,
        ST_STANDBY = 2'b11
    } ctrl_state_t;

    function automatic logic [RATE_W-1:0] rate_div(input logic [1:0] sel);
        logic [RATE_W-1:0] d;
        d = DIV_8K;
        unique case (sel)
            2'b00: d = DIV_5K;
            2'b01: d = DIV_6K;
            2'b10: d = DIV_8K;
            2'b11: d = DIV_8K;
        endcase
        return d;
    endfunction : rate_div

    function automatic logic [LEN_W-1:0] msg_len(input logic [5:0] sel);
        logic [LEN_W-1:0] n;
        n = LEN_W'({1'b0, sel}) + LEN_W'(1);
        return n << LEN_SHIFT;
    endfunction : msg_len

endpackage : speech_pkg

`default_nettype wire

// ---- design/play_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface play_if;
    import speech_pkg::*;
    logic                clk_en;
    logic                osc_tick;
    logic                start;
    logic [CODE_W-1:0]   code;
    logic                done;
    logic                sample_valid;
    logic [SAMPLE_W-1:0] sample;

    modport engine (input  clk_en, osc_tick, start, code,
                    output done, sample_valid, sample);
    modport ctrl   (output clk_en, osc_tick, start, code,
                    input  done, sample_valid, sample);
endinterface : play_if

`default_nettype wire

// ---- design/speech_engine.sv ----
`timescale 1ns/1ps
`default_nettype none

module speech_engine
    import speech_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    play_if.engine    pif
);

    logic                run_reg;
    logic [RATE_W-1:0]   div_reg;
    logic [RATE_W-1:0]   tick_cnt_reg;
    logic [LEN_W-1:0]    left_reg;
    logic [SAMPLE_W-1:0] acc_reg;
    logic [SAMPLE_W-1:0] step_reg;
    logic [SAMPLE_W-1:0] acc_next;

    assign acc_next = acc_reg + step_reg;

    // ------------------------------------------------------------------
    // sample pacing and stand-in decoder
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            run_reg          <= 1'b0;
            div_reg          <= DIV_8K;
            tick_cnt_reg     <= '0;
            left_reg         <= '0;
            acc_reg          <= SAMPLE_MID;
            step_reg         <= SAMPLE_ZERO;
            pif.done         <= 1'b0;
            pif.sample_valid <= 1'b0;
            pif.sample       <= SAMPLE_MID;
        end else if (pif.clk_en) begin
            pif.done         <= 1'b0;
            pif.sample_valid <= 1'b0;
            if (pif.start && !run_reg) begin
                run_reg      <= 1'b1;
                div_reg      <= rate_div(pif.code[7:6]);
                tick_cnt_reg <= '0;
                left_reg     <= msg_len(pif.code[5:0]);
                acc_reg      <= SAMPLE_MID;
                step_reg     <= {3'h0, pif.code[3:0], 2'h1};
            end else if (run_reg && pif.osc_tick) begin
                if (tick_cnt_reg == div_reg - RATE_W'(1)) begin
                    tick_cnt_reg     <= '0;
                    acc_reg          <= acc_next;
                    pif.sample       <= acc_next;
                    pif.sample_valid <= 1'b1;
                    left_reg         <= left_reg - LEN_W'(1);
                    if (left_reg == LEN_W'(1)) begin
                        run_reg  <= 1'b0;
                        pif.done <= 1'b1;
                    end
                end else begin
                    tick_cnt_reg <= tick_cnt_reg + RATE_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_rate_select: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        pif.clk_en && pif.start && !run_reg
        |=> div_reg == rate_div($past(pif.code[7:6])))
        else $error("sample divisor does not match rate select");

    chk_done_length: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        pif.done |-> !run_reg && left_reg == '0)
        else $error("done raised before message length ran out");

endmodule : speech_engine

`default_nettype wire

// ---- design/speech_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module speech_ctrl
    import speech_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_TICKS
)(
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                clk_en,
    input  wire logic                chip_sel_n,
    input  wire logic                play_strobe_n,
    input  wire logic [CODE_W-1:0]   message_code,
    output var  logic                busy_n_out,
    output var  logic                busy_n_oe,
    output var  logic [SAMPLE_W-1:0] voice_current_out,
    output var  logic                voice_sink_en,
    output var  logic                osc_in,
    output var  logic                osc_out
);

    play_if pif ();

    ctrl_state_t          state_reg;
    ctrl_state_t          state_next;
    logic                 strobe_prev_reg;
    logic [CODE_W-1:0]    code_reg;
    logic                 start_reg;
    logic [OSC_CNT_W-1:0] osc_cnt_reg;
    logic                 osc_tick_reg;
    logic [IDLE_W-1:0]    idle_cnt_reg;
    logic                 req;
    logic                 strobe_rise;
    logic                 activity;
    logic                 idle_expired;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    assign req          = !chip_sel_n && !play_strobe_n
                          && strobe_prev_reg;
    assign strobe_rise  = play_strobe_n && !strobe_prev_reg;
    assign activity     = !chip_sel_n || !play_strobe_n;
    assign idle_expired = idle_cnt_reg >= IDLE_W'(IDLE_LIMIT);

    assign pif.clk_en   = clk_en;
    assign pif.osc_tick = osc_tick_reg;
    assign pif.start    = start_reg;
    assign pif.code     = code_reg;

    speech_engine u_engine (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pif     (pif)
    );

    // ------------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (req) begin
                    state_next = ST_ARM;
                end else if (idle_expired) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_ARM: begin
                if (strobe_rise) begin
                    state_next = ST_PLAY;
                end
            end
            ST_PLAY: begin
                if (pif.done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_STANDBY: begin
                if (req) begin
                    state_next = ST_ARM;
                end
            end
        endcase
    end

    // async reset aborts play and leaves standby
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strobe_prev_reg <= 1'b1;
        end else if (clk_en) begin
            strobe_prev_reg <= play_strobe_n;
        end
    end

    // ------------------------------------------------------------------
    // code capture and engine start
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            code_reg  <= '0;
            start_reg <= 1'b0;
        end else if (clk_en) begin
            start_reg <= 1'b0;
            if (state_reg == ST_ARM && strobe_rise) begin
                code_reg  <= message_code;
                start_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // oscillator tick, stopped in standby
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_reg  <= '0;
            osc_tick_reg <= 1'b0;
        end else if (clk_en) begin
            osc_tick_reg <= 1'b0;
            if (state_next == ST_STANDBY) begin
                osc_cnt_reg <= '0;
            end else if (osc_cnt_reg == OSC_CNT_W'(OSC_DIV - 1)) begin
                osc_cnt_reg  <= '0;
                osc_tick_reg <= 1'b1;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + OSC_CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // idle timer in oscillator ticks
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_reg <= '0;
        end else if (clk_en) begin
            if (activity || state_reg != ST_IDLE) begin
                idle_cnt_reg <= '0;
            end else if (osc_tick_reg && !idle_expired) begin
                idle_cnt_reg <= idle_cnt_reg + IDLE_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // pin outputs, taken from the next state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_n_out <= 1'b1;
            busy_n_oe  <= 1'b1;
        end else if (clk_en) begin
            busy_n_out <= !(state_next == ST_ARM
                            || state_next == ST_PLAY);
            busy_n_oe  <= state_next != ST_STANDBY;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_in  <= 1'b0;
            osc_out <= 1'b1;
        end else if (clk_en) begin
            if (state_next == ST_STANDBY) begin
                osc_in  <= 1'b0;
                osc_out <= 1'b1;
            end else if (osc_tick_reg) begin
                osc_in  <= !osc_in;
                osc_out <= osc_in;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            voice_current_out <= SAMPLE_ZERO;
            voice_sink_en     <= 1'b1;
        end else if (clk_en) begin
            voice_sink_en <= state_next != ST_STANDBY;
            if (state_next == ST_STANDBY) begin
                voice_current_out <= SAMPLE_ZERO;
            end else if (pif.sample_valid) begin
                voice_current_out <= pif.sample;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_accept;
        clk_en && req
        && (state_reg == ST_IDLE || state_reg == ST_STANDBY);
    endsequence

    sequence s_capture;
        clk_en && state_reg == ST_ARM && strobe_rise;
    endsequence

    chk_busy_on_accept: assert property (
        s_accept |=> !busy_n_out && busy_n_oe && state_reg == ST_ARM)
        else $error("busy not driven low after accepted start");

    chk_busy_release: assert property (
        $rose(busy_n_out) |-> $past(pif.done) && state_reg == ST_IDLE)
        else $error("busy released before message finished");

    chk_start_ignored: assert property (
        clk_en && state_reg == ST_PLAY && !pif.done
        |=> state_reg == ST_PLAY && $stable(code_reg) && !start_reg)
        else $error("playback disturbed while busy");

    chk_code_capture: assert property (
        s_capture |=> code_reg == $past(message_code) && start_reg
                      ##1 !start_reg || !$past(clk_en))
        else $error("message code not captured on strobe rise");

    chk_standby_entry: assert property (
        clk_en && state_reg == ST_IDLE && idle_expired && !req
        |=> state_reg == ST_STANDBY)
        else $error("standby not entered after idle time");

    chk_standby_wake: assert property (
        clk_en && state_reg == ST_STANDBY && req
        |=> state_reg == ST_ARM ##0 busy_n_oe)
        else $error("start in standby did not wake device");

    chk_busy_float: assert property (
        state_reg == ST_STANDBY |-> !busy_n_oe)
        else $error("busy driven in standby");

    chk_osc_parked: assert property (
        state_reg == ST_STANDBY |-> !osc_in && osc_out && !osc_tick_reg)
        else $error("oscillator pins not parked in standby");

    chk_voice_silent: assert property (
        state_reg == ST_STANDBY
        |-> !voice_sink_en && voice_current_out == SAMPLE_ZERO)
        else $error("voice output sinks current in standby");

    chk_idle_restart: assert property (
        clk_en && activity |=> idle_cnt_reg == '0)
        else $error("idle timer not restarted by activity");

    chk_busy_hold: assert property (
        clk_en && state_reg == ST_PLAY && !pif.done |=> !busy_n_out)
        else $error("busy released during playback");

    chk_arm_wait: assert property (
        clk_en && state_reg == ST_ARM && !strobe_rise
        |=> state_reg == ST_ARM && !busy_n_out)
        else $error("busy dropped while waiting for strobe rise");

    chk_play_entry: assert property (
        s_capture |=> state_reg == ST_PLAY && !busy_n_out)
        else $error("playback not entered after code capture");

    chk_select_gate: assert property (
        clk_en && chip_sel_n && state_reg == ST_IDLE
        |=> state_reg != ST_ARM)
        else $error("start accepted without chip select");

    chk_idle_hold: assert property (
        clk_en && state_reg == ST_IDLE && !idle_expired
        |=> state_reg != ST_STANDBY)
        else $error("standby entered before idle time ran out");

    chk_reset_idle: assert property (
        $rose(rst_b) |-> state_reg == ST_IDLE && busy_n_out && busy_n_oe)
        else $error("device not idle after reset release");

    chk_tick_phase: assert property (
        osc_tick_reg |-> osc_cnt_reg == '0)
        else $error("oscillator tick out of phase with divider");

    chk_sink_awake: assert property (
        state_reg != ST_STANDBY |-> voice_sink_en)
        else $error("voice output disabled outside standby");

    chk_play_oe: assert property (
        state_reg != ST_STANDBY |-> busy_n_oe)
        else $error("busy left floating while awake");

    chk_voice_follow: assert property (
        clk_en && pif.sample_valid && state_next != ST_STANDBY
        |=> voice_current_out == $past(pif.sample))
        else $error("converter code does not follow sample");

endmodule : speech_ctrl

`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model
    import speech_pkg::*;
#(
    parameter int DRV = 2
)(
    input  wire logic              clk_sys,
    output var  logic              rst_b,
    output var  logic              chip_sel_n,
    output var  logic              play_strobe_n,
    output var  logic [CODE_W-1:0] message_code
);
    localparam int RST_HOLD = 12 * OSC_DIV + 4;

    initial begin
        rst_b         = 1'b0;
        chip_sel_n    = 1'b1;
        play_strobe_n = 1'b1;
        message_code  = 8'hA5;
        repeat (10) @(posedge clk_sys);
        #DRV;
        rst_b = 1'b1;
    end

    // --------------------------------------------------------------
    // host actions
    // --------------------------------------------------------------
    // reset long enough for a stable oscillator plus 12 periods
    task automatic do_reset();
        @(posedge clk_sys);
        #DRV;
        rst_b = 1'b0;
        repeat (RST_HOLD) @(posedge clk_sys);
        #DRV;
        rst_b = 1'b1;
    endtask : do_reset

    task automatic start_req(input logic [CODE_W-1:0] code,
                             input logic cs_n);
        @(posedge clk_sys);
        #DRV;
        message_code  = code;
        chip_sel_n    = cs_n;
        play_strobe_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        #DRV;
        play_strobe_n = 1'b1;
        // code held past the rising strobe edge
        repeat (3) @(posedge clk_sys);
        #DRV;
        chip_sel_n   = 1'b1;
        message_code = ~code;
    endtask : start_req

    task automatic select_pulse();
        @(posedge clk_sys);
        #DRV;
        chip_sel_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #DRV;
        chip_sel_n = 1'b1;
    endtask : select_pulse
endmodule : host_model

`default_nettype wire

// ---- tb/speech_message_playback_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module speech_message_playback_control_tb
    import speech_pkg::*;
;
    localparam int IDLE_SIM = 20;
    localparam int TICK     = OSC_DIV;
    localparam int DRV      = 2;
    localparam int SAMP_8K  = int'(DIV_8K) * TICK;

    logic                clk_sys;
    logic                clk_en;
    logic                rst_b;
    logic                chip_sel_n;
    logic                play_strobe_n;
    logic [CODE_W-1:0]   message_code;
    logic                busy_n_out;
    logic                busy_n_oe;
    logic [SAMPLE_W-1:0] voice_current_out;
    logic                voice_sink_en;
    logic                osc_in;
    logic                osc_out;
    wire logic           busy_pin;
    int                  err_total;
    int                  check_count;

    assign busy_pin = busy_n_oe ? busy_n_out : 1'bz;

    speech_ctrl #(.IDLE_LIMIT(IDLE_SIM)) u_dut (
        .clk_sys           (clk_sys),
        .rst_b             (rst_b),
        .clk_en            (clk_en),
        .chip_sel_n        (chip_sel_n),
        .play_strobe_n     (play_strobe_n),
        .message_code      (message_code),
        .busy_n_out        (busy_n_out),
        .busy_n_oe         (busy_n_oe),
        .voice_current_out (voice_current_out),
        .voice_sink_en     (voice_sink_en),
        .osc_in            (osc_in),
        .osc_out           (osc_out)
    );

    host_model #(.DRV(DRV)) u_host (
        .clk_sys       (clk_sys),
        .rst_b         (rst_b),
        .chip_sel_n    (chip_sel_n),
        .play_strobe_n (play_strobe_n),
        .message_code  (message_code)
    );

    always #25 clk_sys = ~clk_sys;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #DRV;
    endtask : tick

    task automatic flag_err(input string what);
        err_total++;
        $display("[ERR] %0t %s", $time, what);
    endtask : flag_err

    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        check_count++;
        if (got !== exp) flag_err(what);
    endtask : check_bit

    task automatic check_vec(input logic [SAMPLE_W-1:0] got,
                             input logic [SAMPLE_W-1:0] exp,
                             input string what);
        check_count++;
        if (got !== exp) flag_err(what);
    endtask : check_vec

    task automatic check_cnt(input int got, input int lo, input int hi,
                             input string what);
        check_count++;
        if (got < lo || got > hi) flag_err(what);
    endtask : check_cnt

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_play_full();
        int                  n;
        int                  n_chg;
        int                  t_first;
        int                  t_second;
        logic [SAMPLE_W-1:0] last_v;
        logic [SAMPLE_W-1:0] first_v;
        n = 0;
        n_chg = 0;
        t_first = 0;
        t_second = 0;
        first_v = '0;
        u_host.start_req(8'h80, 1'b0);
        check_bit(busy_n_out, 1'b0, "busy on start");
        // second request during playback, other rate and length
        u_host.start_req(8'h7F, 1'b0);
        last_v = voice_current_out;
        while (busy_n_out === 1'b0 && n < 20 * SAMP_8K) begin
            tick(1);
            n++;
            if (voice_current_out !== last_v) begin
                n_chg++;
                if (n_chg == 1) first_v = voice_current_out;
                if (n_chg == 1) t_first = n;
                if (n_chg == 2) t_second = n;
            end
            last_v = voice_current_out;
        end
        check_cnt(n, 15 * SAMP_8K, 17 * SAMP_8K, "busy span");
        check_cnt(t_second - t_first, SAMP_8K - TICK, SAMP_8K + TICK,
                  "sample period");
        check_vec(first_v, 9'h101, "sample code");
        check_bit(busy_n_out, 1'b1, "busy after end");
        $display("play_full done");
    endtask : t_play_full

    task automatic t_abort();
        u_host.start_req(8'h01, 1'b0);
        check_bit(busy_n_out, 1'b0, "busy before abort");
        fork
            u_host.do_reset();
        join_none
        tick(20);
        check_bit(busy_n_out, 1'b1, "reset busy");
        check_bit(busy_n_oe, 1'b1, "reset oe");
        check_vec(voice_current_out, 9'h000, "reset voice");
        check_bit(voice_sink_en, 1'b1, "reset sink");
        check_bit(osc_in, 1'b0, "reset osc_in");
        check_bit(osc_out, 1'b1, "reset osc_out");
        wait (rst_b === 1'b1);
        tick(2);
        check_bit(busy_n_out, 1'b1, "busy after abort");
        check_bit(busy_n_oe, 1'b1, "oe after abort");
        $display("abort done");
    endtask : t_abort

    task automatic t_osc_rate();
        int   n;
        logic prev;
        n = 0;
        prev = osc_in;
        repeat (8 * TICK) begin
            tick(1);
            if (osc_in !== prev) n++;
            prev = osc_in;
        end
        check_cnt(n, 8, 8, "osc toggles");
        $display("osc_rate done");
    endtask : t_osc_rate

    task automatic t_freeze();
        int   n;
        logic prev;
        n = 0;
        clk_en = 1'b0;
        prev = osc_in;
        repeat (4 * TICK) begin
            tick(1);
            if (osc_in !== prev) n++;
        end
        clk_en = 1'b1;
        check_cnt(n, 0, 0, "osc frozen");
        $display("freeze done");
    endtask : t_freeze

    task automatic t_select_ignored();
        int n;
        n = 0;
        u_host.start_req(8'h80, 1'b1);
        repeat (10) begin
            tick(1);
            if (busy_n_out !== 1'b1) n++;
        end
        check_cnt(n, 0, 0, "start without select");
        $display("select_ignored done");
    endtask : t_select_ignored

    task automatic t_activity();
        int n;
        n = 0;
        repeat (4) begin
            u_host.select_pulse();
            repeat (400) begin
                tick(1);
                if (busy_n_oe !== 1'b1) n++;
            end
        end
        check_cnt(n, 0, 0, "standby despite activity");
        $display("activity done");
    endtask : t_activity

    task automatic t_standby();
        int n;
        n = 0;
        u_host.select_pulse();
        while (busy_n_oe !== 1'b0 && n < 2 * IDLE_SIM * TICK) begin
            tick(1);
            n++;
        end
        check_cnt(n, (IDLE_SIM - 1) * TICK, (IDLE_SIM + 2) * TICK,
                  "idle span");
        check_bit(busy_pin, 1'bz, "busy floats");
        check_vec(voice_current_out, 9'h000, "voice idle");
        check_bit(voice_sink_en, 1'b0, "sink off");
        tick(100);
        check_bit(osc_in, 1'b0, "osc_in parked");
        check_bit(osc_out, 1'b1, "osc_out parked");
        u_host.start_req(8'h80, 1'b0);
        check_bit(busy_n_oe, 1'b1, "wake oe");
        check_bit(busy_n_out, 1'b0, "wake busy");
        $display("standby done");
    endtask : t_standby

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end
        else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        clk_en = 1'b1;
        err_total = 0;
        check_count = 0;
        wait (rst_b === 1'b1);
        tick(2);
        t_play_full();
        t_abort();
        t_osc_rate();
        t_freeze();
        t_select_ignored();
        t_activity();
        t_standby();
        t_abort();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        flag_err("watchdog expired");
        test_done();
    end
endmodule : speech_message_playback_control_tb

`default_nettype wire
